// ==== cmu_compare_pwm.sv ====
// Compare-match and PWM output unit with APB register access
//
// Operation
// RULE_01 - Compare register checked against Timer1 count every cycle, 16 bits.
// RULE_02 - A match does exactly one configured action: toggle, set, clear, trigger, interrupt.
// RULE_03 - The four-bit mode select field picks the match action.
// RULE_04 - Every compare mode raises the interrupt flag on a match.
// RULE_05 - Software sets the pin direction to output for compare pin activity.
// RULE_06 - Writing zero to the control register forces the compare latch low.
// RULE_07 - Timer1 must run synchronously during compare operation.
// RULE_08 - Mode 1010 only raises the interrupt, pin stays under port control.
// RULE_09 - Mode 1011 match issues the special trigger that resets Timer1.
// RULE_10 - Special trigger also starts an ADC conversion when ADC enabled.
// RULE_11 - In special trigger mode the pin is not taken over.
// RULE_12 - Special trigger output asserts with the detected equality.
// RULE_13 - Timer1 reset lands on the next Timer1 clock edge after match.
// RULE_14 - Trigger-caused Timer1 reset never sets the Timer1 overflow flag.
// RULE_15 - Rewriting compare so match is lost cancels the pending Timer1 reset.
// RULE_16 - PWM mode drives a pulse output with up to 10-bit duty resolution.
// RULE_17 - PWM timing comes from Timer2 period, control, duty and unit control.
// RULE_18 - Software clears pin direction so the PWM driver reaches the pin.
// RULE_19 - Equality sampled on the system clock, one match event per count.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module cmu_compare_pwm
	import cmu_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             srst,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic                  pready,
	output logic [31:0]           prdata,
	output logic                  pslverr,
	// Timer1, Timer2 and ADC side
	input  wire cmu_timer_one_count_t        timer_one_count_in,
	input  wire cmu_tmr2_t        tmr2_in,
	input  wire logic             adc_enabled,
	output logic                  timer_one_reset,
	output logic                  adc_go_set,
	output logic                  special_trigger,
	output logic                  match_flag_set,
	// Output pin
	output logic                  unit_output_pin,
	output logic                  unit_output_pin_oe
);

	logic [CMU_CTRL_W-1:0] ctrl_r;
	logic [CMU_CNT_W-1:0]  compare_value_reg_r;
	logic                  flag_r;
	logic                  cmp_latch_r;
	logic                  eq_prev_r;
	logic [CMU_PWM_W-1:0]  duty_latched_r;
	logic                  pwm_pin_r;
	cmu_spec_state_t       spec_state_r;

	logic [3:0] mode_select_field;
	logic       eq_now;
	logic       match_ev;
	logic       wr_en;
	logic       setup;
	logic       mapped;
	logic       ctrl_zero_wr;
	logic       pwm_mode;
	logic       flag_clr;

	// Pin ownership by mode: off, software interrupt and special
	// trigger modes leave the pin to the port latch
	function automatic logic owns_pin(input logic [3:0] m);
		owns_pin = (m == CMU_M_TOGGLE) || (m == CMU_M_SET) ||
			(m == CMU_M_CLR) || (m[3:2] == CMU_M_PWM_HI);
	endfunction

	function automatic logic is_compare(input logic [3:0] m);
		is_compare = (m == CMU_M_TOGGLE) || (m == CMU_M_SET) ||
			(m == CMU_M_CLR) || (m == CMU_M_SWINT) || (m == CMU_M_SPEC);
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == CMU_OFS_CTRL) || (a == CMU_OFS_CMP) ||
			(a == CMU_OFS_STATUS);
	endfunction

	// Ten-bit duty: compare low byte above the two control LSBs
	function automatic logic [CMU_PWM_W-1:0] duty_word(
		input logic [CMU_CNT_W-1:0] c, input logic [CMU_CTRL_W-1:0] k);
		duty_word = {c[CMU_BYTE_W-1:0], k[CMU_DLSB_LSB +: CMU_DLSB_W]};
	endfunction

	assign mode_select_field = ctrl_r[CMU_MODE_LSB +: CMU_MODE_W]; // RULE_03
	assign pwm_mode  = (mode_select_field[3:2] == CMU_M_PWM_HI);
	assign setup     = psel && !penable;
	assign mapped    = addr_ok(paddr);
	assign wr_en     = psel && penable && pready && pwrite && mapped;
	assign ctrl_zero_wr = wr_en && (paddr == CMU_OFS_CTRL) &&
		(pwdata[CMU_CTRL_W-1:0] == CMU_CTRL_RST);
	assign flag_clr = wr_en && (paddr == CMU_OFS_STATUS) &&
		pwdata[CMU_ST_FLAG];
	// Equality on the system clock; a held count matches only once
	assign eq_now   = (compare_value_reg_r == timer_one_count_in.count); // RULE_01
	assign match_ev = eq_now && !eq_prev_r &&
		is_compare(mode_select_field); // RULE_19

	// APB handshake: one wait-free access phase, answer ready by setup
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			prdata <= CMU_ZERO32;
		end else if (setup && !pwrite) begin
			prdata <= CMU_ZERO32;
			case (paddr)
				CMU_OFS_CTRL: begin
					prdata[CMU_CTRL_W-1:0] <= ctrl_r;
				end
				CMU_OFS_CMP: begin
					prdata[CMU_CNT_W-1:0] <= compare_value_reg_r;
				end
				CMU_OFS_STATUS: begin
					prdata[CMU_ST_FLAG] <= flag_r;
					prdata[CMU_ST_PIN]  <= unit_output_pin;
					prdata[CMU_ST_OWN]  <= unit_output_pin_oe;
					prdata[CMU_ST_PEND] <= (spec_state_r == CMU_S_PEND);
				end
				default: begin
					prdata <= CMU_ZERO32;
				end
			endcase
		end
	end

	// Control and compare registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl_r              <= CMU_CTRL_RST;
			compare_value_reg_r <= CMU_CMP_RST;
		end else if (wr_en) begin
			if (paddr == CMU_OFS_CTRL) begin
				ctrl_r <= pwdata[CMU_CTRL_W-1:0];
			end
			if (paddr == CMU_OFS_CMP) begin
				compare_value_reg_r <= pwdata[CMU_CNT_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			eq_prev_r <= 1'b0;
		end else begin
			eq_prev_r <= eq_now;
		end
	end

	// Sticky match flag, write one to clear; a new match wins the clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			flag_r <= 1'b0;
		end else if (match_ev) begin
			flag_r <= 1'b1; // RULE_04
		end else if (flag_clr) begin
			flag_r <= 1'b0;
		end
	end

	// Event outputs, registered at the edge that samples the equality
	always_ff @(posedge core_clk) begin
		if (srst) begin
			match_flag_set  <= 1'b0;
			special_trigger <= 1'b0;
			adc_go_set      <= 1'b0;
		end else begin
			match_flag_set  <= match_ev; // RULE_04
			special_trigger <= match_ev &&
				(mode_select_field == CMU_M_SPEC); // RULE_12 RULE_09
			adc_go_set      <= match_ev && adc_enabled &&
				(mode_select_field == CMU_M_SPEC); // RULE_10
		end
	end

	// Compare output latch; only one action per match by mode
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmp_latch_r <= 1'b0;
		end else if (ctrl_zero_wr) begin
			cmp_latch_r <= 1'b0; // RULE_06
		end else if (match_ev) begin
			case (mode_select_field) // RULE_02
				CMU_M_TOGGLE: begin
					cmp_latch_r <= !cmp_latch_r;
				end
				CMU_M_SET: begin
					cmp_latch_r <= 1'b1;
				end
				CMU_M_CLR: begin
					cmp_latch_r <= 1'b0;
				end
				default: begin
					cmp_latch_r <= cmp_latch_r; // RULE_08
				end
			endcase
		end
	end

	// Timer1 reset waits for the Timer1 clock edge; lost match cancels it
	always_ff @(posedge core_clk) begin
		if (srst) begin
			spec_state_r    <= CMU_S_IDLE;
			timer_one_reset <= 1'b0;
		end else begin
			timer_one_reset <= 1'b0;
			case (spec_state_r)
				CMU_S_IDLE: begin
					if (match_ev && mode_select_field == CMU_M_SPEC) begin
						spec_state_r <= CMU_S_PEND; // RULE_09
					end
				end
				CMU_S_PEND: begin
					if (!eq_now) begin
						spec_state_r <= CMU_S_IDLE; // RULE_15
					end else if (timer_one_count_in.tick) begin
						// Plain clear, distinct from rollover: no
						// overflow flag is raised by this path
						timer_one_reset <= 1'b1; // RULE_13 RULE_14
						spec_state_r    <= CMU_S_IDLE;
					end
				end
				default: begin
					spec_state_r <= CMU_S_IDLE;
				end
			endcase
		end
	end

	// PWM: duty latched at period start so a mid-period write is glitch-free
	always_ff @(posedge core_clk) begin
		if (srst) begin
			duty_latched_r <= {CMU_PWM_W{1'b0}};
			pwm_pin_r      <= 1'b0;
		end else if (!pwm_mode) begin
			pwm_pin_r <= 1'b0;
		end else if (tmr2_in.period_match) begin
			duty_latched_r <= duty_word(compare_value_reg_r,
				ctrl_r); // RULE_16 RULE_17
			pwm_pin_r <= (duty_word(compare_value_reg_r, ctrl_r) !=
				{CMU_PWM_W{1'b0}});
		end else if (tmr2_in.base == duty_latched_r) begin
			pwm_pin_r <= 1'b0; // RULE_16
		end
	end

	// Pin drive; the direction bit outside still gates the real driver
	always_ff @(posedge core_clk) begin
		if (srst) begin
			unit_output_pin    <= 1'b0;
			unit_output_pin_oe <= 1'b0;
		end else begin
			unit_output_pin    <= pwm_mode ? pwm_pin_r : cmp_latch_r;
			unit_output_pin_oe <= owns_pin(mode_select_field); // RULE_11
		end
	end

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence spec_match_s;
		match_ev && mode_select_field == CMU_M_SPEC;
	endsequence
	sequence spec_hold_s;
		spec_state_r == CMU_S_PEND && eq_now;
	endsequence

	match_flag_a: assert property (match_ev |=> match_flag_set && flag_r) // RULE_04
		else $error("match did not raise the flag");
	trigger_now_a: assert property (spec_match_s |=> special_trigger) // RULE_12
		else $error("special trigger late");
	adc_start_a: assert property (spec_match_s ##0 adc_enabled // RULE_10
		|=> adc_go_set)
		else $error("ADC start missing");
	adc_gate_a: assert property (!adc_enabled |=> !adc_go_set) // RULE_10
		else $error("ADC started while disabled");
	t1_reset_a: assert property (spec_hold_s ##0 timer_one_count_in.tick // RULE_13
		|=> timer_one_reset)
		else $error("Timer1 reset missing");
	reset_cancel_a: assert property ((spec_state_r == CMU_S_PEND) // RULE_15
		&& !eq_now |=> !timer_one_reset && spec_state_r == CMU_S_IDLE)
		else $error("Timer1 reset not cancelled");
	zero_ctrl_a: assert property (ctrl_zero_wr |=> !cmp_latch_r // RULE_06
		##1 !unit_output_pin && !unit_output_pin_oe)
		else $error("control clear left latch high");
	swint_pin_a: assert property (mode_select_field == CMU_M_SWINT // RULE_08
		&& match_ev && !ctrl_zero_wr |=> $stable(cmp_latch_r))
		else $error("interrupt-only mode moved the latch");
	spec_own_a: assert property (mode_select_field == CMU_M_SPEC // RULE_11
		|=> !unit_output_pin_oe)
		else $error("special trigger mode took the pin");
	one_match_a: assert property (match_ev |=> !match_ev) // RULE_19
		else $error("two match events for one count");
	toggle_a: assert property (match_ev && !ctrl_zero_wr // RULE_02
		&& mode_select_field == CMU_M_TOGGLE |=> cmp_latch_r != $past(cmp_latch_r))
		else $error("toggle mode did not toggle");
	pwm_end_a: assert property (pwm_mode && !tmr2_in.period_match // RULE_16
		&& tmr2_in.base == duty_latched_r |=> !pwm_pin_r)
		else $error("PWM high past duty");
	latch_set_a: assert property (match_ev && !ctrl_zero_wr // RULE_02
		&& mode_select_field == CMU_M_SET |=> cmp_latch_r)
		else $error("set mode left the latch low");
	latch_clr_a: assert property (match_ev // RULE_02
		&& mode_select_field == CMU_M_CLR |=> !cmp_latch_r)
		else $error("clear mode left the latch high");
	no_trigger_a: assert property (match_ev // RULE_02
		&& mode_select_field != CMU_M_SPEC |=> !special_trigger)
		else $error("trigger outside special trigger mode");
	trig_pend_a: assert property (spec_match_s // RULE_09
		|=> spec_state_r == CMU_S_PEND)
		else $error("trigger did not arm the Timer1 reset");
	idle_quiet_a: assert property (spec_state_r == CMU_S_IDLE // RULE_15
		|=> !timer_one_reset)
		else $error("Timer1 reset without a pending trigger");
	flag_hold_a: assert property (flag_r && !flag_clr // RULE_04
		|=> flag_r)
		else $error("match flag dropped without a clear");
	swint_own_a: assert property (mode_select_field == CMU_M_SWINT // RULE_08
		|=> !unit_output_pin_oe)
		else $error("interrupt-only mode took the pin");
	pwm_start_a: assert property (pwm_mode && tmr2_in.period_match // RULE_16
		&& duty_word(compare_value_reg_r, ctrl_r) != {CMU_PWM_W{1'b0}}
		|=> pwm_pin_r)
		else $error("PWM did not start its pulse");

endmodule

// ==== cmu_pkg.sv ====
// Constants, register map and carrier types for the compare/PWM unit
package cmu_pkg;
	// Register byte offsets on the APB bus
	localparam logic [7:0] CMU_OFS_CTRL   = 8'h00;
	localparam logic [7:0] CMU_OFS_CMP    = 8'h04;
	localparam logic [7:0] CMU_OFS_STATUS = 8'h08;
	// Control register fields
	localparam int CMU_MODE_LSB = 0;
	localparam int CMU_MODE_W   = 4;
	localparam int CMU_DLSB_LSB = 4;
	localparam int CMU_DLSB_W   = 2;
	localparam int CMU_CTRL_W   = 6;
	// Status register bit positions
	localparam int CMU_ST_FLAG  = 0;
	localparam int CMU_ST_PIN   = 1;
	localparam int CMU_ST_OWN   = 2;
	localparam int CMU_ST_PEND  = 3;
	// Widths
	localparam int CMU_CNT_W    = 16;
	localparam int CMU_PWM_W    = 10;
	localparam int CMU_BYTE_W   = 8;
	// Reset values
	localparam logic [CMU_CTRL_W-1:0] CMU_CTRL_RST = 6'h00;
	localparam logic [CMU_CNT_W-1:0]  CMU_CMP_RST  = 16'h0000;
	localparam logic [31:0]           CMU_ZERO32   = 32'h0000_0000;
	// Mode select field encodings
	localparam logic [3:0] CMU_M_OFF    = 4'h0;
	localparam logic [3:0] CMU_M_TOGGLE = 4'h2;
	localparam logic [3:0] CMU_M_SET    = 4'h8;
	localparam logic [3:0] CMU_M_CLR    = 4'h9;
	localparam logic [3:0] CMU_M_SWINT  = 4'hA;
	localparam logic [3:0] CMU_M_SPEC   = 4'hB;
	localparam logic [1:0] CMU_M_PWM_HI = 2'h3;

	// Timer1 side: count pair and its clock edge enable
	typedef struct packed {
		logic [CMU_CNT_W-1:0] count;
		logic                 tick;
	} cmu_timer_one_count_t;

	// Timer2 side: 10-bit time base and its period match
	typedef struct packed {
		logic [CMU_PWM_W-1:0] base;
		logic                 period_match;
	} cmu_tmr2_t;

	typedef enum logic [1:0] {
		CMU_S_IDLE = 2'b01,
		CMU_S_PEND = 2'b10
	} cmu_spec_state_t;
endpackage

// ==== cmu_tmr_model.sv ====
// Timer1 and Timer2 stand-ins feeding the unit's timer inputs
`timescale 1ns/1ps
module cmu_tmr_model
	import cmu_pkg::*;
#(
	parameter int T2_PER = 15
) (
	// Clock and control
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic run,
	input  wire logic restart,
	// Unit side
	input  wire logic timer_one_reset,
	output cmu_timer_one_count_t timer_one_count_in,
	output cmu_tmr2_t tmr2_in,
	output logic      ovf_flag
);
	logic [1:0]  phase_r;
	logic [9:0]  base_r;
	logic [15:0] cnt_r;
	logic        t1_tick;
	// Slow tick so a match holds for four core cycles
	assign t1_tick = run && (phase_r == 2'h3);
	// Whole-struct drives: one driver per carrier
	assign timer_one_count_in = '{count: cnt_r, tick: t1_tick};
	assign tmr2_in = '{base: base_r, period_match: (base_r == 10'h000)};
	always_ff @(posedge core_clk) begin
		if (srst || restart) begin
			phase_r <= 2'h0;
		end else if (run) begin
			phase_r <= phase_r + 2'h1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst || restart || timer_one_reset) begin
			cnt_r <= 16'h0000;
		end else if (t1_tick) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
	// Only a real wrap sets overflow, never the trigger clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ovf_flag <= 1'b0;
		end else if (t1_tick && cnt_r == 16'hFFFF) begin
			ovf_flag <= 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst || base_r == T2_PER[9:0]) begin
			base_r <= 10'h000;
		end else begin
			base_r <= base_r + 10'h001;
		end
	end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the compare/PWM unit
`timescale 1ns/1ps
module tb_top
	import cmu_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        adc_enabled = 1'b1;
	logic        run = 1'b0;
	logic        restart = 1'b0;
	logic        pin_direction_bit = 1'b1;
	logic        pad_level;
	logic        pready, pslverr, ovf_flag, timer_one_reset, adc_go_set;
	logic        special_trigger, match_flag_set;
	logic        unit_output_pin, unit_output_pin_oe;
	logic [31:0] prdata;
	cmu_timer_one_count_t   timer_one_count_in;
	cmu_tmr2_t   tmr2_in;
	logic [15:0] hit_cnt, cnt_d;
	int          n_mismatch = 0, compares = 0, h;
	int          n_flag = 0, n_trig = 0, n_adc = 0, n_rst = 0;
	logic [3:0]  md [5] = '{CMU_M_CLR, CMU_M_TOGGLE, CMU_M_TOGGLE, CMU_M_SET, CMU_M_SWINT};
	logic        pv [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	logic        ov [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

	always #4 core_clk = ~core_clk;

	// Pad sees the unit only when it owns the pin and direction is output
	assign pad_level = (unit_output_pin_oe && !pin_direction_bit) ?
		unit_output_pin : 1'b0;

	cmu_compare_pwm DUT (.core_clk(core_clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.timer_one_count_in(timer_one_count_in), .tmr2_in(tmr2_in), .adc_enabled(adc_enabled),
		.timer_one_reset(timer_one_reset), .adc_go_set(adc_go_set),
		.special_trigger(special_trigger), .match_flag_set(match_flag_set),
		.unit_output_pin(unit_output_pin),
		.unit_output_pin_oe(unit_output_pin_oe));
	cmu_tmr_model #(.T2_PER(15)) tmr (.core_clk(core_clk), .srst(srst),
		.run(run), .restart(restart), .timer_one_reset(timer_one_reset),
		.timer_one_count_in(timer_one_count_in), .tmr2_in(tmr2_in), .ovf_flag(ovf_flag));

	// Pulse counters; count seen one cycle before the flag
	always @(posedge core_clk) begin
		cnt_d <= timer_one_count_in.count;
		if (match_flag_set === 1'b1) begin
			n_flag++;
			hit_cnt = cnt_d;
		end
		if (special_trigger === 1'b1) n_trig++;
		if (adc_go_set === 1'b1) n_adc++;
		if (timer_one_reset === 1'b1) n_rst++;
	end

	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		chk_val(q, x);
		chk_bit(e, xe);
	endtask
	task go;
		@(posedge core_clk);
		restart <= 1'b1;
		run <= 1'b1;
		@(posedge core_clk);
		restart <= 1'b0;
	endtask
	task wait_flag;
		int s, n;
		s = n_flag;
		n = 0;
		while (n_flag == s && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		chk_bit(n_flag != s, 1'b1);
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		pin_direction_bit <= 1'b0;
		rd(CMU_OFS_CTRL, 32'h0, 1'b0);
		rd(CMU_OFS_CMP, 32'h0, 1'b0);
		rd(8'h0C, 32'h0, 1'b1);
		wr(CMU_OFS_CMP, 32'h0000_0010);
		for (int i = 0; i < 5; i++) begin
			wr(CMU_OFS_CTRL, {28'h0, md[i]});
			go();
			wait_flag();
			repeat (2) @(posedge core_clk);
			chk_val(hit_cnt, 32'h10);
			chk_bit(unit_output_pin_oe, ov[i]);
			if (ov[i]) chk_bit(unit_output_pin, pv[i]);
		end
		rd(CMU_OFS_STATUS, 32'h3, 1'b0);
		wr(CMU_OFS_STATUS, 32'h1);
		rd(CMU_OFS_STATUS, 32'h2, 1'b0);
		chk_val(n_trig, 32'h0);
		wr(CMU_OFS_CTRL, 32'h0);
		repeat (2) @(posedge core_clk);
		chk_bit(unit_output_pin, 1'b0);
		wr(CMU_OFS_CTRL, {28'h0, CMU_M_SPEC});
		go();
		wait_flag();
		repeat (8) @(posedge core_clk);
		chk_val(n_trig, 32'h1);
		chk_val(n_adc, 32'h1);
		chk_val(n_rst, 32'h1);
		chk_bit(timer_one_count_in.count < 16'h0010, 1'b1);
		chk_bit(ovf_flag, 1'b0);
		chk_bit(unit_output_pin_oe, 1'b0);
		adc_enabled <= 1'b0;
		wait_flag();
		repeat (8) @(posedge core_clk);
		chk_val(n_adc, 32'h1);
		chk_val(n_rst, 32'h2);
		go();
		wait_flag();
		run <= 1'b0;
		repeat (20) @(posedge core_clk);
		chk_val(n_flag, 32'h8);
		wr(CMU_OFS_CMP, 32'h0000_0100);
		run <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk_val(n_rst, 32'h2);
		chk_bit(timer_one_count_in.count > 16'h0010, 1'b1);
		wr(CMU_OFS_CMP, 32'h0000_0001);
		wr(CMU_OFS_CTRL, 32'h0000_002C);
		pin_direction_bit <= 1'b0;
		repeat (40) @(posedge core_clk);
		h = 0;
		repeat (32) begin
			@(posedge core_clk);
			if (pad_level === 1'b1) h++;
		end
		chk_val(h, 32'd12);
		chk_bit(unit_output_pin_oe, 1'b1);
		wr(CMU_OFS_CTRL, 32'h0);
		repeat (2) @(posedge core_clk);
		chk_bit(unit_output_pin_oe, 1'b0);
		print_verdict();
	end
endmodule
